// File: abc_conv_model.sv
// converter stand-in answering conversion requests promptly or slowly
`timescale 1ns/100ps
module abc_conv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_req,
  input wire logic slow,
  output logic conv_done,
  output logic [15:0] conv_data
);
  logic [2:0] wait_ff;
  logic [15:0] val_ff;
  // one result per countdown; data inverts every cycle between results
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 3'h1;
      val_ff <= 16'h1357;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (!conv_req) begin
        wait_ff <= 3'h1;
      end else if (wait_ff == 3'h0) begin
        conv_done <= 1'b1;
        conv_data <= val_ff;
        val_ff <= val_ff + 16'h1d3b;
        wait_ff <= slow ? 3'h4 : 3'h1;
      end else begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule : abc_conv_model

// File: abc_pkg.sv
// constants and carrier types for the acquisition board control registers
package abc_pkg;
  // register byte offsets
  localparam logic [11:0] ABC_OFF_ID = 12'h000;
  localparam logic [11:0] ABC_OFF_CSR = 12'h002;
  localparam logic [11:0] ABC_OFF_CFG = 12'h004;
  localparam logic [11:0] ABC_OFF_RATE = 12'h006;
  localparam logic [11:0] ABC_OFF_ICTL = 12'h008;
  localparam logic [11:0] ABC_OFF_IVEC = 12'h00a;
  localparam logic [11:0] ABC_OFF_SRST = 12'h00c;
  localparam logic [11:0] ABC_OFF_STRG = 12'h00e;
  localparam logic [11:0] ABC_OFF_GAIN = 12'h010;
  localparam logic [11:0] ABC_OFF_TLO = 12'h020;
  localparam logic [11:0] ABC_OFF_THI = 12'h022;
  localparam logic [11:0] ABC_OFF_CNT = 12'h024;
  localparam logic [11:0] ABC_OFF_TSET = 12'h026;
  localparam logic [11:0] ABC_MEM_LO = 12'h080;
  localparam logic [11:0] ABC_MEM_HI = 12'hffe;
  localparam logic [11:0] ABC_WORD_MASK = 12'hffe;
  // control/status bit positions
  localparam int ABC_CSR_LED = 15;
  localparam int ABC_CSR_FMT = 14;
  localparam int ABC_CSR_TM_HI = 13;
  localparam int ABC_CSR_TM_LO = 12;
  localparam int ABC_CSR_CASC = 11;
  localparam int ABC_CSR_FLAG = 10;
  localparam int ABC_CSR_CAL = 7;
  localparam int ABC_CSR_RDY = 6;
  localparam int ABC_CSR_ARM = 5;
  localparam int ABC_CSR_TRG = 4;
  localparam logic [15:0] ABC_CSR_WMASK = 16'hfc00;
  // configuration field positions
  localparam int ABC_CFG_ISRC = 10;
  localparam int ABC_CFG_GM_HI = 9;
  localparam int ABC_CFG_GM_LO = 8;
  localparam int ABC_CFG_SM_HI = 7;
  localparam int ABC_CFG_SM_LO = 6;
  localparam int ABC_CFG_GRP_HI = 5;
  // trigger source and mode codes
  localparam logic [1:0] ABC_TRG_SOFT = 2'h0;
  localparam logic [1:0] ABC_TRG_EXT = 2'h1;
  localparam logic [1:0] ABC_TRG_TIMER = 2'h2;
  localparam logic [1:0] ABC_SM_AUTO = 2'h0;
  localparam logic [1:0] ABC_SM_SINGLE = 2'h1;
  localparam logic [1:0] ABC_GM_X10 = 2'h1;
  localparam logic [15:0] ABC_ZERO16 = 16'h0000;
  // host bus request
  typedef struct packed {
    logic sel;
    logic wr;
    logic [1:0] be;
    logic [11:0] addr;
    logic [15:0] wdata;
  } abc_bus_req_type;
endpackage : abc_pkg

// File: abc_regs.sv
// control register bank, buffer memory and scan sequencer of the acquisition board
// Overview of operation
// - decode identity, control, config, reset, trigger offsets
// - constant identity word with channel count code
// - control/status takes byte and word accesses
// - indicator disable bit, one turns Indicator_disable
// - encoding bit selects two's complement results
// - two-bit trigger source select, default software
// - cascade bit joins timers into 32 bits
// - flag bit sets ready at midpoint
// - calibration done clears when calibration starts
// - ready set at scan end, memory read clears
// - armed until trigger or any reset
// - triggered until scan end in single or random mode (auto mode stays triggered), or any reset
// - configuration field layout, byte or word access
// - buffer and scratch words mapped, reserved ranges
// - scan modes auto, single and random
// - gain mode fixed x1, x10 or table
// - interrupt source counter or ready flag
`timescale 1ns/100ps
module abc_regs
  import abc_pkg::*;
#(
  parameter logic [1:0] CHAN_CODE = 2'h0,
  parameter logic [13:0] ID_PATTERN = 14'h0a5, // arbitrary identity value
  parameter int CAL_CYCLES = 1000,
  parameter int SCAN_LEN = 64,
  parameter int MEM_WORDS = 1984
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire abc_bus_req_type bus_req,
  output logic bus_ack,
  output logic [15:0] bus_rdata,
  input wire logic ext_trigger,
  output logic conv_req,
  output logic [5:0] conv_channel,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic led_on,
  output logic gain_x10,
  output logic gain_from_table,
  output logic [15:0] gain_table,
  output logic [15:0] rate_setting,
  output logic [15:0] irq_control,
  output logic [15:0] irq_vector,
  output logic irq_event
);

  typedef enum logic [1:0] {ST_CAL, ST_ARMED, ST_CONV, ST_STOP} abc_state_type;

  typedef struct packed {
    abc_state_type st;
    logic [15:0] control_and_status;
    logic [15:0] cfg;
    logic [15:0] rate;
    logic [15:0] ictl;
    logic [15:0] ivec;
    logic [15:0] gain;
    logic [15:0] tlo;
    logic [15:0] thi;
    logic [15:0] cnt;
    logic [15:0] tset;
    logic [15:0] conv_cnt;
    logic [31:0] timer;
    logic [15:0] cal_cnt;
    logic cal_done;
    logic ready;
    logic [10:0] idx;
    logic [2:0] ext_sync;
    logic ack;
    logic [15:0] rdata;
    logic [MEM_WORDS-1:0][15:0] mem;
  } abc_regs_type;

  abc_regs_type r_ff;
  abc_regs_type nxt_r;

  logic [11:0] adr;
  logic [10:0] widx;
  logic in_mem;
  logic wr;
  logic rd;
  logic trig_evt;
  logic fire;
  logic [1:0] tsrc;
  logic [1:0] smode;
  logic [15:0] sample;
  logic [31:0] reload;

  // byte-lane merge of a write into a word
  function automatic logic [15:0] abc_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    abc_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : abc_merge

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.ack = 1'b0;
    adr = bus_req.addr & ABC_WORD_MASK;
    widx = 11'((adr - ABC_MEM_LO) >> 1);
    in_mem = (adr >= ABC_MEM_LO) && (adr <= ABC_MEM_HI) && (widx < 11'(MEM_WORDS));
    wr = bus_req.sel && bus_req.wr;
    rd = bus_req.sel && !bus_req.wr;
    tsrc = r_ff.control_and_status[ABC_CSR_TM_HI:ABC_CSR_TM_LO];
    smode = r_ff.cfg[ABC_CFG_SM_HI:ABC_CFG_SM_LO];
    sample = r_ff.control_and_status[ABC_CSR_FMT] ? {~conv_data[15], conv_data[14:0]} : conv_data;
    reload = r_ff.control_and_status[ABC_CSR_CASC] ? {r_ff.thi, r_ff.tlo} : {ABC_ZERO16, r_ff.tlo};
    nxt_r.ext_sync = {r_ff.ext_sync[1:0], ext_trigger};
    // interval timer, runs only when it is the trigger source
    fire = 1'b0;
    if (tsrc == ABC_TRG_TIMER) begin
      if (r_ff.timer == 32'h0000_0000) begin
        fire = 1'b1;
        nxt_r.timer = reload;
      end else begin
        nxt_r.timer = r_ff.timer - 32'h0000_0001;
      end
    end else begin
      nxt_r.timer = reload;
    end
    // trigger source select, reserved code never triggers
    unique case (tsrc)
      ABC_TRG_SOFT: trig_evt = wr && (adr == ABC_OFF_STRG);
      ABC_TRG_EXT: trig_evt = r_ff.ext_sync[1] && !r_ff.ext_sync[2];
      ABC_TRG_TIMER: trig_evt = fire;
      default: trig_evt = 1'b0;
    endcase
    // a host memory read clears ready; a scan setting it later wins
    if (rd && in_mem) begin
      nxt_r.ready = 1'b0;
    end
    // scan sequencer
    unique case (r_ff.st)
      ST_CAL: begin
        if (r_ff.cal_cnt == ABC_ZERO16) begin
          nxt_r.cal_done = 1'b1;
          nxt_r.st = ST_ARMED;
        end else begin
          nxt_r.cal_cnt = r_ff.cal_cnt - 16'h0001;
        end
      end
      ST_ARMED: begin
        if (trig_evt) begin
          nxt_r.st = ST_CONV;
          nxt_r.idx = 11'h000;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          nxt_r.mem[smode[1] ? 11'h000 : r_ff.idx] = sample;
          nxt_r.conv_cnt = r_ff.conv_cnt + 16'h0001;
          nxt_r.idx = r_ff.idx + 11'h001;
          if (r_ff.control_and_status[ABC_CSR_FLAG] && r_ff.idx == 11'(SCAN_LEN / 2 - 1)) begin
            nxt_r.ready = 1'b1;
          end
          if (smode[1] || r_ff.idx == 11'(SCAN_LEN - 1)) begin
            nxt_r.idx = 11'h000;
            if (!r_ff.control_and_status[ABC_CSR_FLAG] || smode[1]) begin
              nxt_r.ready = 1'b1;
            end
            nxt_r.st = (smode == ABC_SM_AUTO) ? ST_CONV : ST_ARMED;
          end
        end
      end
      ST_STOP: begin
        nxt_r.st = ST_ARMED;
      end
    endcase
    // register writes, control/status drops status and unused bits
    if (wr) begin
      unique case (adr)
        ABC_OFF_CSR: nxt_r.control_and_status = (abc_merge(r_ff.control_and_status, bus_req.wdata, bus_req.be) & ABC_CSR_WMASK);
        ABC_OFF_CFG: nxt_r.cfg = abc_merge(r_ff.cfg, bus_req.wdata, bus_req.be);
        ABC_OFF_RATE: nxt_r.rate = abc_merge(r_ff.rate, bus_req.wdata, bus_req.be);
        ABC_OFF_ICTL: nxt_r.ictl = abc_merge(r_ff.ictl, bus_req.wdata, bus_req.be);
        ABC_OFF_IVEC: nxt_r.ivec = abc_merge(r_ff.ivec, bus_req.wdata, bus_req.be);
        ABC_OFF_GAIN: nxt_r.gain = abc_merge(r_ff.gain, bus_req.wdata, bus_req.be);
        ABC_OFF_TLO: nxt_r.tlo = abc_merge(r_ff.tlo, bus_req.wdata, bus_req.be);
        ABC_OFF_THI: nxt_r.thi = abc_merge(r_ff.thi, bus_req.wdata, bus_req.be);
        ABC_OFF_CNT: nxt_r.cnt = abc_merge(r_ff.cnt, bus_req.wdata, bus_req.be);
        ABC_OFF_TSET: nxt_r.tset = abc_merge(r_ff.tset, bus_req.wdata, bus_req.be);
        default: begin
          if (in_mem) begin
            nxt_r.mem[widx] = abc_merge(r_ff.mem[widx], bus_req.wdata, bus_req.be);
          end
        end
      endcase
    end
    // software reset clears controls except interrupt regs, recalibrates
    if (wr && adr == ABC_OFF_SRST) begin
      nxt_r.control_and_status = ABC_ZERO16;
      nxt_r.cfg = ABC_ZERO16;
      nxt_r.rate = ABC_ZERO16;
      nxt_r.gain = ABC_ZERO16;
      nxt_r.tlo = ABC_ZERO16;
      nxt_r.thi = ABC_ZERO16;
      nxt_r.cnt = ABC_ZERO16;
      nxt_r.tset = ABC_ZERO16;
      nxt_r.conv_cnt = ABC_ZERO16;
      nxt_r.ready = 1'b0;
      nxt_r.idx = 11'h000;
      nxt_r.cal_done = 1'b0;
      nxt_r.cal_cnt = 16'(CAL_CYCLES);
      nxt_r.st = ST_CAL;
    end
    // read data, unmapped and write-only locations read zero
    if (rd) begin
      nxt_r.ack = 1'b1;
      unique case (adr)
        ABC_OFF_ID: nxt_r.rdata = {ID_PATTERN, CHAN_CODE};
        ABC_OFF_CSR: nxt_r.rdata = r_ff.control_and_status | ({12'h000, r_ff.cal_done, r_ff.ready, r_ff.st == ST_ARMED,
                                   r_ff.st == ST_CONV} << ABC_CSR_TRG);
        ABC_OFF_CFG: nxt_r.rdata = r_ff.cfg;
        ABC_OFF_RATE: nxt_r.rdata = r_ff.rate;
        ABC_OFF_ICTL: nxt_r.rdata = r_ff.ictl;
        ABC_OFF_IVEC: nxt_r.rdata = r_ff.ivec;
        ABC_OFF_GAIN: nxt_r.rdata = r_ff.gain;
        ABC_OFF_TLO: nxt_r.rdata = r_ff.tlo;
        ABC_OFF_THI: nxt_r.rdata = r_ff.thi;
        ABC_OFF_CNT: nxt_r.rdata = r_ff.cnt;
        default: nxt_r.rdata = in_mem ? r_ff.mem[widx] : ABC_ZERO16;
      endcase
    end else if (wr) begin
      nxt_r.ack = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, system reset starts calibration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
      r_ff.st <= ST_CAL;
      r_ff.cal_cnt <= 16'(CAL_CYCLES);
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus_ack = r_ff.ack;
  assign bus_rdata = r_ff.rdata;
  assign conv_req = (r_ff.st == ST_CONV);
  // random mode converts the group channel, otherwise walk the block
  assign conv_channel = r_ff.cfg[ABC_CFG_SM_HI] ? r_ff.cfg[ABC_CFG_GRP_HI:0] :
                        (r_ff.idx[5:0] + r_ff.cfg[ABC_CFG_GRP_HI:0]);
  assign led_on = !r_ff.control_and_status[ABC_CSR_LED];
  assign gain_x10 = (r_ff.cfg[ABC_CFG_GM_HI:ABC_CFG_GM_LO] == ABC_GM_X10);
  assign gain_from_table = r_ff.cfg[ABC_CFG_GM_HI];
  assign gain_table = r_ff.gain;
  assign rate_setting = r_ff.rate;
  assign irq_control = r_ff.ictl;
  assign irq_vector = r_ff.ivec;
  // counter source when selected, else the ready flag
  assign irq_event = r_ff.cfg[ABC_CFG_ISRC] ? (r_ff.cnt != ABC_ZERO16 && r_ff.conv_cnt == r_ff.cnt) : r_ff.ready;

endmodule : abc_regs

// File: abc_regs_monitor.sv
// concurrent checks on the ports of the control register bank
`timescale 1ns/100ps
module abc_regs_monitor
  import abc_pkg::*;
#(
  parameter logic [1:0] CHAN_CODE = 2'h0,
  parameter logic [13:0] ID_PATTERN = 14'h0a5 // arbitrary identity value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire abc_bus_req_type bus_req,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata,
  input wire logic conv_req,
  input wire logic led_on,
  input wire logic gain_x10,
  input wire logic gain_from_table
);
  logic rd_id;
  logic rd_csr;
  logic wr_csr_hi;
  logic wr_cfg_hi;
  logic wr_srst;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // decode of the access under way
  assign rd_id = bus_req.sel && !bus_req.wr && bus_req.addr[11:1] == ABC_OFF_ID[11:1];
  assign rd_csr = bus_req.sel && !bus_req.wr && bus_req.addr[11:1] == ABC_OFF_CSR[11:1];
  assign wr_csr_hi = bus_req.sel && bus_req.wr && bus_req.be[1] && bus_req.addr[11:1] == ABC_OFF_CSR[11:1];
  assign wr_cfg_hi = bus_req.sel && bus_req.wr && bus_req.be[1] && bus_req.addr[11:1] == ABC_OFF_CFG[11:1];
  assign wr_srst = bus_req.sel && bus_req.wr && bus_req.addr[11:1] == ABC_OFF_SRST[11:1];
  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_follows: assert property (bus_req.sel |=> bus_ack)
    else $error("no acknowledge after an access");
  chk_ack_unasked: assert property (!bus_req.sel |=> !bus_ack)
    else $error("acknowledge without an access");
  chk_id_word: assert property (rd_id |=> bus_rdata == {ID_PATTERN, CHAN_CODE})
    else $error("identity word wrong");
  chk_csr_unused: assert property (rd_csr |=> (bus_rdata & 16'h030f) == 16'h0000)
    else $error("unused status bits not zero");
  chk_led_write: assert property (wr_csr_hi |=> led_on == !$past(bus_req.wdata[15]))
    else $error("indicator does not follow its bit");
  chk_gain_mode: assert property (wr_cfg_hi |=> gain_x10 == ($past(bus_req.wdata[9:8]) == 2'h1) &&
    gain_from_table == $past(bus_req.wdata[9]))
    else $error("gain outputs do not follow gain mode");
  chk_srst_clears: assert property (wr_srst |=> led_on && !conv_req)
    else $error("soft reset left control state");
  chk_reset_quiet: assert property ($rose(rst_n) |-> (led_on && !conv_req) [*4])
    else $error("activity straight after reset");
endmodule : abc_regs_monitor

bind abc_regs abc_regs_monitor #(.CHAN_CODE(CHAN_CODE), .ID_PATTERN(ID_PATTERN)) u_mon (.clk(clk), .rst_n(rst_n),
  .bus_req(bus_req), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .conv_req(conv_req), .led_on(led_on),
  .gain_x10(gain_x10), .gain_from_table(gain_from_table));

// File: abc_regs_tb_top.sv
// self-checking bench for the control register bank
`timescale 1ns/100ps
module abc_regs_tb_top;
  import abc_pkg::*;
  localparam int SCAN = 8;
  localparam logic [13:0] ID_PAT = 14'h1c3; // arbitrary identity value
  logic clk, rst_n, ext_trg, slow, bus_ack, conv_req, conv_done, led_on, gain_x10, gain_from_table, irq_event;
  logic [15:0] bus_rdata, conv_data, gain_table, rate_setting, irq_control, irq_vector, v, r, c;
  logic [5:0] conv_channel;
  abc_bus_req_type req;
  logic [15:0] got_q[$];
  int error_cnt, n_compared, i, f, k, seed;
  abc_regs #(.CHAN_CODE(2'h1), .ID_PATTERN(ID_PAT), .CAL_CYCLES(5), .SCAN_LEN(SCAN)) DUT (.clk(clk),
    .rst_n(rst_n), .bus_req(req), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .ext_trigger(ext_trg),
    .conv_req(conv_req), .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data),
    .led_on(led_on), .gain_x10(gain_x10), .gain_from_table(gain_from_table), .gain_table(gain_table),
    .rate_setting(rate_setting), .irq_control(irq_control), .irq_vector(irq_vector), .irq_event(irq_event));
  abc_conv_model u_conv (.clk(clk), .rst_n(rst_n), .conv_req(conv_req), .slow(slow), .conv_done(conv_done),
    .conv_data(conv_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // one access: request for one cycle, answer one cycle later
  task automatic acc(input logic w, input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    req <= '{sel: 1'b1, wr: w, be: be, addr: a, wdata: d};
    @(posedge clk);
    req.sel <= 1'b0;
    @(posedge clk);
    r = bus_rdata;
    check({15'h0, bus_ack}, 16'h0001);
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [15:0] want);
    acc(1'b0, a, 2'h3, 16'h0000);
    check(r, want);
  endtask : rd
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  // clock, result collector and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (conv_done === 1'b1) got_q.push_back(conv_data);
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    wrap_up;
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    ext_trg = 1'b0;
    slow = 1'b0;
    seed = 32'hb8a47d88;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ABC_OFF_ID, {ID_PAT, 2'h1});
    rd(ABC_OFF_CSR, 16'h00a0);
    rd(ABC_OFF_CFG, 16'h0000);
    acc(1'b1, ABC_OFF_ID, 2'h3, 16'hffff);
    rd(ABC_OFF_ID, {ID_PAT, 2'h1});
    rd(12'h014, 16'h0000);
    rd(ABC_OFF_STRG, 16'h0000);
    $display("test reset defaults done");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      v[13] = 1'b0;
      acc(1'b1, ABC_OFF_CSR, 2'h3, v);
      rd(ABC_OFF_CSR, (v & ABC_CSR_WMASK) | 16'h00a0);
      check({15'h0, led_on}, {15'h0, ~v[15]});
      acc(1'b1, ABC_OFF_CSR, 2'h1, 16'h0000);
      rd(ABC_OFF_CSR, (v & ABC_CSR_WMASK) | 16'h00a0);
      c = $random(seed);
      acc(1'b1, ABC_OFF_CFG, 2'h3, c);
      rd(ABC_OFF_CFG, c);
      check({14'h0, gain_from_table, gain_x10}, {14'h0, c[9], c[9:8] == 2'h1});
      acc(1'b1, ABC_OFF_CFG, 2'h1, 16'h0000);
      rd(ABC_OFF_CFG, {c[15:8], 8'h00});
    end
    acc(1'b1, ABC_OFF_CSR, 2'h2, 16'h0000);
    rd(ABC_OFF_CSR, 16'h00a0);
    $display("test register access done");
    // interval long enough that the timer fires once in the timer-triggered scenario
    acc(1'b1, ABC_OFF_TLO, 2'h3, 16'h0100);
    for (f = 0; f < 5; f++) begin
      slow <= f[0];
      v = (f == 1) ? 16'h4000 : (f == 3) ? 16'h1000 : (f == 4) ? 16'h2000 : 16'h0000;
      acc(1'b1, ABC_OFF_CSR, 2'h3, v);
      acc(1'b1, ABC_OFF_CFG, 2'h3, (f >= 2) ? 16'h0085 : 16'h0040);
      got_q.delete();
      acc(1'b1, ABC_OFF_STRG, 2'h3, 16'h0000);
      ext_trg <= (f == 3);
      for (k = 0; k < 400 && got_q.size() < ((f >= 2) ? 1 : SCAN); k++) @(posedge clk);
      ext_trg <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ABC_OFF_CSR, v | 16'h00e0);
      check({15'h0, irq_event}, 16'h0001);
      if (f >= 2) check({10'h0, conv_channel}, 16'h0005);
      for (i = 0; i < got_q.size(); i++)
        rd(ABC_MEM_LO + 12'(2 * i), got_q[i] ^ {v[14], 15'h0});
      check(16'(got_q.size()), (f >= 2) ? 16'h0001 : 16'(SCAN));
      rd(ABC_OFF_CSR, v | 16'h00a0);
      check({15'h0, irq_event}, 16'h0000);
    end
    $display("test scans done");
    acc(1'b1, ABC_OFF_ICTL, 2'h3, 16'h5a5a);
    acc(1'b1, ABC_OFF_IVEC, 2'h3, 16'h00c3);
    acc(1'b1, ABC_OFF_RATE, 2'h3, 16'h0321);
    acc(1'b1, ABC_OFF_GAIN, 2'h3, 16'h3c3c);
    check(rate_setting, 16'h0321);
    check(gain_table, 16'h3c3c);
    acc(1'b1, ABC_OFF_CSR, 2'h3, 16'hc000);
    acc(1'b1, ABC_OFF_SRST, 2'h3, 16'h1234);
    rd(ABC_OFF_CSR, 16'h0000);
    check(irq_control, 16'h5a5a);
    check(irq_vector, 16'h00c3);
    check(rate_setting, 16'h0000);
    check(gain_table, 16'h0000);
    rd(ABC_OFF_CFG, 16'h0000);
    repeat (8) @(posedge clk);
    rd(ABC_OFF_CSR, 16'h00a0);
    $display("test soft reset done");
    wrap_up;
  end
endmodule : abc_regs_tb_top
